// [core/wfa_frame_assembler.sv]
// Frame assembler: builds one broadcast radio frame per accepted start pulse and
// streams it out byte by byte, lowest byte of each field first.
// Assumes the payload source supplies the payload bytes in order and the
// byte sink applies back-pressure through tx_ready.
`timescale 1ns/1ps
module wfa_frame_assembler
    import wfa_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         start,      // Request a frame, one pulse
    input  wire wfa_req_type  req,        // Kind, channel, data fields
    input  wire logic         pay_valid,  // Payload byte offered
    input  wire logic [7:0]   pay_data,
    output logic              pay_ready,  // Payload byte taken
    output logic              tx_valid,   // Output byte present
    output wfa_byte_type      tx_byte,
    input  wire logic         tx_ready,   // Sink takes the byte
    output logic              busy,       // Frame in progress
    output logic              chan_err,   // Start refused, bad channel
    output logic [4:0]        chan_cur,   // Channel in use
    output logic [11:0]       freq_mhz    // Its centre frequency
);

    ////////////////////////////////////////////////////////////////////////
    // State
    wfa_state_type st_r;          // Field being produced
    wfa_state_type slot_st_r;     // Field of the byte now on the output
    logic [5:0]    cnt_r;         // Byte index within the field
    logic [5:0]    slot_cnt_r;    // Index of the byte now on the output
    wfa_req_type   req_r;         // Request held for the frame
    logic [7:0]    seq_r;         // Sequence number of this frame
    logic          tx_valid_r;    // Output slot full
    wfa_byte_type  tx_byte_r;     // Output slot contents
    logic          chan_err_r;
    logic [4:0]    chan_r;
    logic [11:0]   freq_r;
    logic [15:0]   crc;           // Running check sum

    // Combinational
    logic          take;          // Start accepted this cycle
    logic          chan_ok;       // Requested channel in range
    logic          ins;           // Payload byte made here, not taken
    logic          load;          // Output slot loads a byte
    logic          fld_end;       // Last byte of the current field
    logic          crc_en;
    logic [7:0]    byte_nxt;
    logic [5:0]    flen;

    // Bytes of the current field
    function automatic logic [5:0] fld_len(input wfa_state_type s,
                                           input wfa_kind_type  k);
        case (s)
            ST_PRE:  fld_len = PRE_LEN;
            ST_FCF:  fld_len = FCF_LEN;
            ST_ADDR: fld_len = ADDR_LEN;
            ST_PAY:  fld_len = pay_len(k);
            ST_FCS:  fld_len = FCS_LEN;
            default: fld_len = ONE_LEN;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Request acceptance; a bad channel never starts a frame
    assign chan_ok = (req.chan >= CHAN_MIN) && (req.chan <= CHAN_MAX);
    assign take    = start && (st_r == ST_IDLE) && chan_ok;

    ////////////////////////////////////////////////////////////////////////
    // Next output byte for the current field and index
    always_comb
    begin
        flen     = fld_len(st_r, req_r.kind);
        fld_end  = (cnt_r == flen - 6'h01);
        ins      = (st_r == ST_PAY) && (req_r.kind == KIND_DATA) &&
                   (cnt_r == CMD_IDX || cnt_r == STAT_IDX);
        load     = (!tx_valid_r || tx_ready) && (st_r != ST_IDLE) &&
                   (st_r != ST_PAY || ins || pay_valid);
        byte_nxt = PRE_BYTE;
        case (st_r)
            ST_SFD:  byte_nxt = SFD_BYTE;
            ST_LEN:  byte_nxt = {2'b00, pay_len(req_r.kind)}
                                + LEN_OVH;
            // Low byte first, so 0x01 then 0x08
            ST_FCF:  byte_nxt = cnt_r[0] ? FCF_WORD[15:8]
                                         : FCF_WORD[7:0];
            ST_SEQ:  byte_nxt = seq_r;
            ST_ADDR: byte_nxt = DST_WORD[8*cnt_r[1:0] +: 8];
            ST_PAY:
            begin
                // Command and status slots of a data telegram
                if (ins && cnt_r == CMD_IDX)
                    byte_nxt = req_r.push ? CMD_PUSH : CMD_REL;
                else if (ins)
                    byte_nxt = req_r.btn;
                else
                    byte_nxt = pay_data;
            end
            ST_FCS:  byte_nxt = cnt_r[0] ? crc[15:8] : crc[7:0];
            default: byte_nxt = PRE_BYTE;
        endcase
        // Sum covers length byte through payload only
        crc_en = load && (st_r >= ST_LEN) && (st_r <= ST_PAY);
    end

    // Payload source is only drained when the slot can take its byte
    assign pay_ready = (!tx_valid_r || tx_ready) && (st_r == ST_PAY) &&
                       !ins;

    ////////////////////////////////////////////////////////////////////////
    // Field sequencer; the payload directly follows the address
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_r  <= ST_IDLE;
            cnt_r <= 6'h00;
        end
        else if (take)
        begin
            st_r  <= ST_PRE;
            cnt_r <= 6'h00;
        end
        else if (load && !fld_end)
            cnt_r <= cnt_r + 6'h01;
        else if (load)
        begin
            cnt_r <= 6'h00;
            case (st_r)
                ST_PRE:  st_r <= ST_SFD;
                ST_SFD:  st_r <= ST_LEN;
                ST_LEN:  st_r <= ST_FCF;
                ST_FCF:  st_r <= ST_SEQ;
                ST_SEQ:  st_r <= ST_ADDR;
                ST_ADDR: st_r <= ST_PAY;
                ST_PAY:  st_r <= ST_FCS;
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request latch; kind fixes the payload size for the whole frame
    always_ff @(posedge clk)
    begin
        if (rst)
            req_r <= '{KIND_DATA, CHAN_MIN, 1'b0, 8'h00};
        else if (take)
            req_r <= req;
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel and frequency; a refused request leaves both unchanged
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            chan_r     <= CHAN_MIN;
            freq_r     <= FREQ_BASE;
            chan_err_r <= 1'b0;
        end
        else
        begin
            chan_err_r <= start && (st_r == ST_IDLE) && !chan_ok;
            if (take)
            begin
                chan_r <= req.chan;
                freq_r <= FREQ_BASE + 12'(({7'h00, req.chan} -
                          {7'h00, CHAN_MIN}) * FREQ_STEP);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequence number advances as the final byte is loaded
    always_ff @(posedge clk)
    begin
        if (rst)
            seq_r <= SEQ_INIT;
        else if (load && st_r == ST_FCS && fld_end)
            seq_r <= seq_r + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output slot; one registered byte, held until the sink takes it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tx_valid_r <= 1'b0;
            tx_byte_r  <= '0;
            slot_st_r  <= ST_IDLE;
            slot_cnt_r <= 6'h00;
        end
        else if (load)
        begin
            tx_valid_r <= 1'b1;
            tx_byte_r  <= '{byte_nxt, (st_r == ST_FCS) && fld_end};
            slot_st_r  <= st_r;
            slot_cnt_r <= cnt_r;
        end
        else if (tx_ready)
            tx_valid_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Check sum unit, cleared at each accepted start
    wfa_crc16 u_crc
    (
        .clk   (clk),
        .rst   (rst),
        .clr   (take),
        .en    (crc_en),
        .din   (byte_nxt),
        .crc_r (crc)
    );

    assign tx_valid = tx_valid_r;
    assign tx_byte  = tx_byte_r;
    assign busy     = (st_r != ST_IDLE) || tx_valid_r;
    assign chan_err = chan_err_r;
    assign chan_cur = chan_r;
    assign freq_mhz = freq_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the produced stream
    logic tx_hs;
    assign tx_hs = tx_valid_r && tx_ready;

    sequence pre_done;
        tx_hs && slot_st_r == ST_PRE && slot_cnt_r == 6'h03;
    endsequence

    sequence addr_done;
        tx_hs && slot_st_r == ST_ADDR && slot_cnt_r == 6'h03;
    endsequence

    chan_range_a: assert property (@(posedge clk) disable iff (rst)
        take |=> chan_r >= 5'h0b && chan_r <= 5'h1a)
        else $error("channel outside 11..26 accepted");
    freq_map_a: assert property (@(posedge clk) disable iff (rst)
        take |=> freq_r == 12'h965 + 12'(($past(req.chan) - 5'h0b) * 5)
                 && freq_r <= FREQ_TOP)
        else $error("centre frequency mismatch");
    pre_zero_a: assert property (@(posedge clk) disable iff (rst)
        tx_valid_r && slot_st_r == ST_PRE |-> tx_byte_r.data == 8'h00)
        else $error("preamble byte not zero");
    sfd_next_a: assert property (@(posedge clk) disable iff (rst)
        pre_done |=> tx_valid_r && slot_st_r == ST_SFD &&
                     tx_byte_r.data == 8'ha7)
        else $error("delimiter does not follow preamble");
    len_val_a: assert property (@(posedge clk) disable iff (rst)
        tx_valid_r && slot_st_r == ST_LEN |->
        tx_byte_r.data == (req_r.kind == KIND_COM   ? 8'h2e :
                           req_r.kind == KIND_DECOM ? 8'h18 : 8'h19))
        else $error("length byte wrong for kind");
    fcf_order_a: assert property (@(posedge clk) disable iff (rst)
        tx_valid_r && slot_st_r == ST_FCF |->
        tx_byte_r.data == (slot_cnt_r[0] ? 8'h08 : 8'h01))
        else $error("frame control byte wrong");
    seq_step_a: assert property (@(posedge clk) disable iff (rst)
        load && st_r == ST_FCS && fld_end |=> seq_r == $past(seq_r) + 8'h01)
        else $error("sequence number did not step");
    addr_bcast_a: assert property (@(posedge clk) disable iff (rst)
        tx_valid_r && slot_st_r == ST_ADDR |-> tx_byte_r.data == 8'hff)
        else $error("destination not broadcast");
    pay_follow_a: assert property (@(posedge clk) disable iff (rst)
        addr_done |-> st_r == ST_PAY)
        else $error("payload does not follow address");
    fcs_low_a: assert property (@(posedge clk) disable iff (rst)
        load && st_r == ST_FCS && cnt_r == 6'h00 |=>
        tx_byte_r.data == crc[7:0] && !tx_byte_r.last)
        else $error("check sum low byte wrong");
    kind_legal_a: assert property (@(posedge clk) disable iff (rst)
        busy |-> req_r.kind != 2'b11)
        else $error("illegal telegram kind");
    cmd_byte_a: assert property (@(posedge clk) disable iff (rst)
        tx_valid_r && slot_st_r == ST_PAY && slot_cnt_r == 6'h0a &&
        req_r.kind == KIND_DATA |->
        tx_byte_r.data == (req_r.push ? 8'h69 : 8'h6a))
        else $error("data command byte wrong");

endmodule

// [core/wfa_pkg.sv]
// Constants and types shared by the frame assembler and its CRC unit.
// Assumes one core clock and a synchronous active-high reset.
package wfa_pkg;

    // Channel range and centre-frequency mapping, in MHz
    localparam logic [4:0]  CHAN_MIN  = 5'h0b;     // Lowest channel, 11
    localparam logic [4:0]  CHAN_MAX  = 5'h1a;     // Highest channel, 26
    localparam logic [11:0] FREQ_BASE = 12'h965;   // 2405 MHz at channel 11
    localparam logic [11:0] FREQ_STEP = 12'h005;   // 5 MHz per channel
    localparam logic [11:0] FREQ_TOP  = 12'h9b0;   // 2480 MHz at channel 26

    // Fixed header bytes
    localparam logic [7:0]  PRE_BYTE  = 8'h00;     // Preamble byte value
    localparam logic [7:0]  SFD_BYTE  = 8'ha7;     // Start-of-frame delimiter
    localparam logic [15:0] FCF_WORD  = 16'h0801;  // Frame control field
    localparam logic [31:0] DST_WORD  = 32'hffffffff; // PAN id and address

    // Field lengths in bytes
    localparam logic [5:0]  PRE_LEN   = 6'h04;
    localparam logic [5:0]  ONE_LEN   = 6'h01;
    localparam logic [5:0]  FCF_LEN   = 6'h02;
    localparam logic [5:0]  ADDR_LEN  = 6'h04;
    localparam logic [5:0]  FCS_LEN   = 6'h02;

    // Payload sizes and resulting length bytes
    localparam logic [5:0]  PAY_DATA  = 6'h10;     // 16 bytes
    localparam logic [5:0]  PAY_COM   = 6'h25;     // 37 bytes
    localparam logic [5:0]  PAY_DECOM = 6'h0f;     // 15 bytes
    localparam logic [7:0]  LEN_OVH   = 8'h09;     // FCF, seq, addr, FCS
    localparam logic [7:0]  LEN_DATA  = 8'h19;
    localparam logic [7:0]  LEN_COM   = 8'h2e;
    localparam logic [7:0]  LEN_DECOM = 8'h18;

    // Data telegram command bytes inserted by the framer
    localparam logic [7:0]  CMD_PUSH  = 8'h69;
    localparam logic [7:0]  CMD_REL   = 8'h6a;
    localparam logic [5:0]  CMD_IDX   = 6'h0a;     // Payload index of command
    localparam logic [5:0]  STAT_IDX  = 6'h0b;     // Payload index of status

    // Reflected CRC16 for x^16+x^12+x^5+1, LSB-first over the air
    localparam logic [15:0] CRC_POLY  = 16'h8408;
    localparam logic [15:0] CRC_INIT  = 16'h0000;
    localparam logic [7:0]  SEQ_INIT  = 8'h00;

    // Telegram kinds
    typedef enum logic [1:0] {
        KIND_DATA  = 2'b00,
        KIND_COM   = 2'b01,
        KIND_DECOM = 2'b10
    } wfa_kind_type;

    // Frame builder states, one per field
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_PRE  = 4'b0001,
        ST_SFD  = 4'b0010,
        ST_LEN  = 4'b0011,
        ST_FCF  = 4'b0100,
        ST_SEQ  = 4'b0101,
        ST_ADDR = 4'b0110,
        ST_PAY  = 4'b0111,
        ST_FCS  = 4'b1000
    } wfa_state_type;

    // Frame request taken with the start pulse
    typedef struct packed {
        wfa_kind_type kind;   // Telegram kind
        logic [4:0]   chan;   // Channel number
        logic         push;   // Data telegram: 1 push, 0 release
        logic [7:0]   btn;    // Data telegram: button status byte
    } wfa_req_type;

    // One byte on the outgoing stream
    typedef struct packed {
        logic [7:0] data;
        logic       last;     // Final check sum byte
    } wfa_byte_type;

    // Payload byte count of a telegram kind
    function automatic logic [5:0] pay_len(input wfa_kind_type k);
        case (k)
            KIND_COM:   pay_len = PAY_COM;
            KIND_DECOM: pay_len = PAY_DECOM;
            default:    pay_len = PAY_DATA;
        endcase
    endfunction

endpackage

// [core/wfa_crc16.sv]
// Running CRC16 over the bytes of a frame, LSB of each byte first.
// Assumes the caller clears it before a frame and enables it per byte.
`timescale 1ns/1ps
module wfa_crc16
    import wfa_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clr,    // Restart at the initial value
    input  wire logic        en,     // Fold din into the sum
    input  wire logic [7:0]  din,
    output logic      [15:0] crc_r   // Current sum, low byte sent first
);

    ////////////////////////////////////////////////////////////////////////
    // One byte folded bit by bit in reflected form
    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0]  d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
        begin
            if (r[0] ^ d[i])
                r = (r >> 1) ^ CRC_POLY;
            else
                r = r >> 1;
        end
        crc_byte = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sum register; clear wins so a new frame never inherits old bytes
    always_ff @(posedge clk)
    begin
        if (rst || clr)
            crc_r <= CRC_INIT;
        else if (en)
            crc_r <= crc_byte(crc_r, din);
    end

endmodule

// [bench/wfa_sink_model.sv]
// Receiver model: takes frame bytes off the assembler's output stream.
// Assumes one clock shared with the assembler and a synchronous reset.
`timescale 1ns/1ps
module wfa_sink_model
    import wfa_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         clr,      // Forget the previous frame
    input  wire logic         slow,     // Stall the stream now and then
    input  wire logic         tx_valid,
    input  wire wfa_byte_type tx_byte,
    output logic              tx_ready,
    output logic [6:0]        n,        // Bytes taken this frame
    output logic              done      // Final byte taken
);
    logic [7:0] cap [0:63];             // Captured bytes, in air order
    logic [2:0] cyc_r;                  // Stall pattern counter

    ////////////////////////////////////////////////////////////////////
    // Ready pattern: a slow sink refuses three cycles out of eight, so
    // the framer must hold a byte across several refused edges
    always_ff @(posedge clk)
    begin
        cyc_r    <= rst ? 3'h0 : cyc_r + 3'h1;
        tx_ready <= !rst && !(slow && cyc_r < 3'h3);
    end

    ////////////////////////////////////////////////////////////////////
    // Capture; bytes are stored in arrival order, low byte first
    always_ff @(posedge clk)
    begin
        if (rst || clr)
        begin
            n    <= 7'h00;
            done <= 1'b0;
        end
        else if (tx_valid && tx_ready && n < 7'h40)
        begin
            cap[n[5:0]] <= tx_byte.data;
            n           <= n + 7'h01;
            done        <= tx_byte.last;
        end
    end
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the frame assembler with a receiver model.
// Assumes the assembler's hand-over timing; one 40 MHz clock.
`timescale 1ns/1ps
module tb_top;
    import wfa_pkg::*;

    typedef struct packed {
        wfa_kind_type kind;
        logic [4:0]   chan;
        logic         push;
        logic [7:0]   btn;
        logic         slow;             // Stalling sink and source
        logic [7:0]   len;              // Expected length byte
        logic [11:0]  freq;             // Expected centre MHz
    } wfa_row_type;

    logic         clk;
    logic         rst;
    logic         start;
    wfa_req_type  req;
    logic         pay_valid;
    logic [7:0]   pay_data;
    logic         pay_ready;
    logic         tx_valid;
    wfa_byte_type tx_byte;
    logic         tx_ready;
    logic         busy;
    logic         chan_err;
    logic [4:0]   chan_cur;
    logic [11:0]  freq_mhz;
    logic         slow;
    logic         pclr;             // Restart payload source
    logic         sclr;             // Restart sink
    logic [5:0]   pidx;             // Next source payload byte
    logic [2:0]   pcyc;             // Source stall pattern
    logic [6:0]   sn;
    logic         sdone;
    logic [7:0]   seq_exp;          // Sequence number of next frame
    logic [7:0]   e [0:63];         // Expected frame
    int           fails;
    int           n_checks;

    wfa_row_type rows [0:3] = '{
        '{KIND_DATA,  5'h0b, 1'b1, 8'h05, 1'b0, 8'h19, 12'h965},
        '{KIND_DATA,  5'h1a, 1'b0, 8'h00, 1'b1, 8'h19, 12'h9b0},
        '{KIND_COM,   5'h0f, 1'b0, 8'h00, 1'b1, 8'h2e, 12'h979},
        '{KIND_DECOM, 5'h14, 1'b0, 8'h00, 1'b0, 8'h18, 12'h992}};

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    wfa_frame_assembler i_dut (.clk(clk), .rst(rst), .start(start),
        .req(req), .pay_valid(pay_valid), .pay_data(pay_data),
        .pay_ready(pay_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_ready(tx_ready), .busy(busy), .chan_err(chan_err),
        .chan_cur(chan_cur), .freq_mhz(freq_mhz));

    wfa_sink_model i_sink (.clk(clk), .rst(rst), .clr(sclr), .slow(slow),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
        .n(sn), .done(sdone));

    ////////////////////////////////////////////////////////////////////
    // Payload source: byte j carries 0x30+j; a slow source withholds
    // its byte now and then, which must not disturb the order. A byte
    // once offered stays offered until the framer takes it.
    assign pay_data = 8'h30 + {2'b00, pidx};
    always @(posedge clk)
    begin
        if (rst)
        begin
            pcyc      <= 3'h0;
            pay_valid <= 1'b0;
        end
        else
        begin
            pcyc      <= pcyc + 3'h1;
            pay_valid <= (pay_valid && !pay_ready) ||
                         !(slow && pcyc == 3'h4);
        end
        if (rst || pclr)
            pidx <= 6'h00;
        else if (pay_valid && pay_ready)
            pidx <= pidx + 6'h01;
    end

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Reflected CRC, one byte LSB first, no final inversion
    function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                            input logic [7:0] d);
        logic b;
        for (int k = 0; k < 8; k++)
        begin
            b = c[0] ^ d[k];
            c = c >> 1;
            if (b)
                c = c ^ CRC_POLY;
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Builds the expected frame, sends one request and compares; dup
    // repeats start mid-frame, which must be ignored
    task automatic run_frame(input wfa_row_type r, input bit dup);
        int         pl;
        logic [15:0] c;
        pl = r.len - 8'h09;
        for (int i = 0; i < 4; i++)
        begin
            e[i]   = 8'h00;
            e[9+i] = 8'hff;
        end
        e[4] = 8'ha7;
        e[5] = r.len;
        e[6] = 8'h01;
        e[7] = 8'h08;
        e[8] = seq_exp;
        for (int i = 0; i < pl; i++)
            e[13+i] = 8'h30 + i[7:0];
        if (r.kind == KIND_DATA)
        begin
            e[23] = r.push ? 8'h69 : 8'h6a;
            e[24] = r.btn;
            for (int i = 12; i < 16; i++)
                e[13+i] = 8'h30 + i[7:0] - 8'h02;
        end
        c = 16'h0000;
        for (int i = 5; i < 13 + pl; i++)
            c = crc_upd(c, e[i]);
        e[13+pl] = c[7:0];
        e[14+pl] = c[15:8];
        @(posedge clk);
        slow  <= r.slow;
        pclr  <= 1'b1;
        sclr  <= 1'b1;
        start <= 1'b1;
        req   <= '{r.kind, r.chan, r.push, r.btn};
        @(posedge clk);
        pclr  <= 1'b0;
        sclr  <= 1'b0;
        // The sink's done flag clears only at this edge, so skip it once
        for (int k = 0; k < 600 && (k == 0 || !sdone); k++)
        begin
            start <= dup && k == 8;
            @(posedge clk);
        end
        start <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check("frame bytes", sn, 7'(15 + pl));
        check("length byte", i_sink.cap[5], r.len);
        check("crc", {i_sink.cap[14+pl], i_sink.cap[13+pl]}, c);
        for (int i = 0; i < 4; i++)
            check("preamble byte", i_sink.cap[i], e[i]);
        check("delimiter", i_sink.cap[4], e[4]);
        check("length field", i_sink.cap[5], e[5]);
        check("fcf low", i_sink.cap[6], e[6]);
        check("fcf high", i_sink.cap[7], e[7]);
        check("sequence", i_sink.cap[8], e[8]);
        for (int i = 9; i < 13; i++)
            check("address byte", i_sink.cap[i], e[i]);
        for (int i = 13; i < 13 + pl; i++)
            check("payload byte", i_sink.cap[i], e[i]);
        for (int i = 13 + pl; i < 15 + pl; i++)
            check("fcs byte", i_sink.cap[i], e[i]);
        check("idle after frame", {tx_valid, busy}, 2'b00);
        check("channel", chan_cur, r.chan);
        check("frequency", freq_mhz, r.freq);
        seq_exp = seq_exp + 8'h01;
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1;
        seq_exp = 8'h00;
        check("reset outputs", {tx_valid, busy, chan_err, pay_ready}, 4'h0);
        check("reset byte", tx_byte, 9'h000);
        check("reset channel", chan_cur, 5'h0b);
        check("reset frequency", freq_mhz, 12'h965);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Main sequence: table rows, then refusals and a mid-frame reset
    initial
    begin
        fails = 0;
        n_checks = 0;
        start = 1'b0;
        req = '0;
        slow = 1'b0;
        pclr = 1'b1;
        sclr = 1'b0;
        do_reset();
        foreach (rows[i])
            run_frame(rows[i], 1'b0);
        run_frame(rows[0], 1'b1);
        // Channels just outside the range are refused with a pulse
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            start <= 1'b1;
            req   <= '{KIND_DATA, i ? 5'h1b : 5'h0a, 1'b1, 8'h00};
            @(posedge clk);
            start <= 1'b0;
            #1;
            check("refusal pulse", chan_err, 1'b1);
            @(posedge clk);
            #1;
            check("refusal ends", {chan_err, busy}, 2'b00);
            check("no frame", tx_valid, 1'b0);
            check("channel kept", chan_cur, 5'h0b);
        end
        // Reset in mid-frame restarts the sequence number
        @(posedge clk);
        start <= 1'b1;
        req   <= '{KIND_COM, 5'h0c, 1'b0, 8'h00};
        @(posedge clk);
        start <= 1'b0;
        repeat (12) @(posedge clk);
        do_reset();
        run_frame(rows[3], 1'b0);
        final_report();
    end

    // Watchdog: the whole sequence needs well under 2000 cycles
    initial
    begin
        #(25 * 20000);
        fails++;
        final_report();
    end
endmodule
